/* logic/pil_cfg.svh */
// Constants for the pump interlock logic
`ifndef PIL_CFG_SVH
`define PIL_CFG_SVH
`define PIL_NUM_PUMPS      8
`define PIL_NUM_INPUTS     8
`define PIL_SEL_W          4
`define PIL_SEL_NONE       4'h0
`define PIL_SEL_MAX        4'h8
`define PIL_RELAY_FN_W     7
`define PIL_FN_PUMP_LO     7'h32
`define PIL_FN_PUMP_HI     7'h38
`define PIL_FN_PWR_ALARM   7'h0c
`define PIL_DELAY_W        14
`define PIL_DELAY_RESET    14'h0005
`define PIL_DELAY_MAX      14'h270f
`define PIL_CLK_HZ         40000000
`define PIL_SECOND_CYCLES  (`PIL_CLK_HZ)
`endif

/* logic/pil_pkg.sv */
// Types for the pump interlock logic
`default_nettype none
`include "pil_cfg.svh"
package pil_pkg;
	typedef logic [`PIL_SEL_W-1:0] pil_sel_t;
	typedef struct packed {
		pil_sel_t autoManualSelect;
		pil_sel_t remoteEnableSelect;
		pil_sel_t runConfirmSelect;
		pil_sel_t faultASelect;
		pil_sel_t faultBSelect;
		pil_sel_t faultResetSelect;
		logic [`PIL_RELAY_FN_W-1:0] relayFunction;
		logic [`PIL_DELAY_W-1:0]    runCheckDelay;
	} pil_pump_cfg_t;
	typedef struct packed {
		logic pumpFailed;
		logic runFault;
		logic faultA;
		logic faultB;
		logic remoteStatus;
		logic autoMode;
		logic available;
	} pil_pump_stat_t;
	typedef enum logic [1:0] {
		PIL_IDLE  = 2'b00,
		PIL_WAIT  = 2'b01,
		PIL_CHECK = 2'b10
	} pil_run_state_t;
endpackage : pil_pkg
`default_nettype wire

/* logic/pil_pump_interlock.sv */
// Pump interlock: input mapping, latched faults, power-fail handling
`timescale 1ns/10ps
`default_nettype none
`include "pil_cfg.svh"

module pil_pump_interlock #(
	parameter int NUM_PUMPS    = `PIL_NUM_PUMPS,
	parameter int NUM_INPUTS   = `PIL_NUM_INPUTS,
	parameter int SECOND_CYCLES = `PIL_SECOND_CYCLES
) (
	input  wire logic                                   clk,
	input  wire logic                                   rst,
	input  wire logic [NUM_INPUTS-1:0]                  scaledInputValue,
	input  wire pil_pkg::pil_pump_cfg_t [NUM_PUMPS-1:0] pumpCfg,
	input  wire pil_pkg::pil_sel_t                      powerFailSelect,
	input  wire pil_pkg::pil_sel_t                      globalResetSelect,
	input  wire logic [NUM_PUMPS-1:0]                   relayFunctionAlarm,
	input  wire logic [NUM_PUMPS-1:0]                   pumpRunRequest,
	input  wire logic [NUM_PUMPS-1:0]                   hostRemoteWrite,
	input  wire logic [NUM_PUMPS-1:0]                   hostRemoteValue,
	input  wire logic [NUM_PUMPS-1:0]                   hostFaultClear,
	input  wire logic                                   runMode,
	output logic [NUM_PUMPS-1:0]                        pumpRelay,
	output logic [NUM_PUMPS-1:0]                        powerFailAlarmRelay,
	output logic                                        powerFailFlag,
	output pil_pkg::pil_pump_stat_t [NUM_PUMPS-1:0]     pumpStatus
);
	import pil_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic [NUM_INPUTS-1:0] syncA;
	logic [NUM_INPUTS-1:0] syncB;
	logic [NUM_INPUTS-1:0] syncC;
	logic [NUM_INPUTS-1:0] inVal;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
		end else begin
			syncA <= scaledInputValue;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inVal <= '0;
		end else if (syncB == syncC) begin
			inVal <= syncB;
		end
	end

	// ==========================================================
	// Helpers
	// zero or above 8 means unused, else input n
	function automatic logic pickIn(input pil_sel_t sel, input logic [NUM_INPUTS-1:0] v);
		logic r;
		r = 1'b0;
		for (int i = 1; i <= NUM_INPUTS; i++)
			if (sel == pil_sel_t'(i))
				r = v[i-1];
		return r;
	endfunction

	function automatic logic used(input pil_sel_t sel);
		return (sel != `PIL_SEL_NONE) && (sel <= `PIL_SEL_MAX);
	endfunction

	// relay function inside the pump range
	function automatic logic pumpFn(input logic [`PIL_RELAY_FN_W-1:0] fn);
		return (fn >= `PIL_FN_PUMP_LO) && (fn <= `PIL_FN_PUMP_HI);
	endfunction

	// Latched flag: set wins over clear
	function automatic logic latchNext(input logic set, input logic held, input logic clr);
		return set | (held & ~clr);
	endfunction

	function automatic logic [`PIL_DELAY_W-1:0] incSec(input logic [`PIL_DELAY_W-1:0] v);
		return v + `PIL_DELAY_W'(1);
	endfunction

	function automatic logic [31:0] incTick(input logic [31:0] v);
		return v + 32'h0000_0001;
	endfunction

	// ==========================================================
	// Power failure
	wire pfIn = pickIn(powerFailSelect, inVal);
	wire pfNow = used(powerFailSelect) & pfIn;

	// Reset contact edge detection
	logic [NUM_PUMPS-1:0] resetPrev;
	logic                 globalPrev;
	wire globalIn = pickIn(globalResetSelect, inVal);
	// global rising edge in run mode
	wire globalEdge = runMode & used(globalResetSelect) & globalIn & ~globalPrev;

	logic [NUM_PUMPS-1:0] resetNow;
	logic [NUM_PUMPS-1:0] failAny;
	logic [NUM_PUMPS-1:0] isPump;
	logic [NUM_PUMPS-1:0] checkDue;

	pil_run_state_t runState [NUM_PUMPS];
	logic [`PIL_DELAY_W-1:0] secCnt [NUM_PUMPS];
	logic [31:0]             tick   [NUM_PUMPS];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powerFailFlag <= 1'b0;
		end else begin
			powerFailFlag <= pfNow;
		end
	end

	// alarm relays only during the event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powerFailAlarmRelay <= '0;
		end else begin
			powerFailAlarmRelay <= pfNow ? relayFunctionAlarm : '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			globalPrev <= 1'b0;
		end else begin
			globalPrev <= globalIn;
		end
	end

	// ==========================================================
	// Per-pump logic
	for (genvar p = 0; p < NUM_PUMPS; p++) begin : gPump
		pil_pump_cfg_t           c;
		pil_pump_stat_t          cur;
		pil_pump_stat_t          next_status;
		pil_run_state_t          next_state;
		logic [`PIL_DELAY_W-1:0] next_secCnt;
		logic [31:0]             next_tick;
		logic                    next_relay;

		assign c   = pumpCfg[p];
		assign cur = pumpStatus[p];

		// ==========================================================
		// Field inputs for this pump
		// pump relay functions only
		assign isPump[p] = pumpFn(c.relayFunction);
		// 1 auto, 0 manual; unallocated means auto
		wire autoIn   = used(c.autoManualSelect) ? pickIn(c.autoManualSelect, inVal) : 1'b1;
		wire confirm  = pickIn(c.runConfirmSelect, inVal);
		wire faultAIn = used(c.faultASelect) & pickIn(c.faultASelect, inVal);
		wire faultBIn = used(c.faultBSelect) & pickIn(c.faultBSelect, inVal);
		wire rstIn    = pickIn(c.faultResetSelect, inVal);
		wire remoteIn = pickIn(c.remoteEnableSelect, inVal);

		// ==========================================================
		// Reset and fault decisions
		// per-pump contact rising edge
		wire contactEdge = runMode & used(c.faultResetSelect) & rstIn & ~resetPrev[p];
		assign resetNow[p] = globalEdge | hostFaultClear[p] | contactEdge;
		assign failAny[p]  = cur.runFault | cur.faultA | cur.faultB;
		assign checkDue[p] = (runState[p] == PIL_CHECK) & used(c.runConfirmSelect);
		// new alarms ignored in power fail
		wire arm           = isPump[p] & ~pfNow;
		wire next_runFault = checkDue[p] & ~confirm & arm;
		wire next_faultA   = faultAIn & arm;
		wire next_faultB   = faultBIn & arm;
		wire newFault      = next_runFault | next_faultA | next_faultB;

		wire hostRemote  = hostRemoteWrite[p] ? hostRemoteValue[p] : cur.remoteStatus;
		wire next_remote = used(c.remoteEnableSelect) ? remoteIn : hostRemote;
		// failed or manual pumps leave duty
		wire next_avail  = isPump[p] & autoIn & ~(failAny[p] | newFault);
		// stop failed pumps and in power fail
		assign next_relay = pumpRunRequest[p] & next_avail & ~pfNow;

		// latched flags, set wins over clear
		always_comb begin
			next_status              = cur;
			next_status.runFault     = latchNext(next_runFault, cur.runFault, resetNow[p]);
			next_status.faultA       = latchNext(next_faultA, cur.faultA, resetNow[p]);
			next_status.faultB       = latchNext(next_faultB, cur.faultB, resetNow[p]);
			next_status.pumpFailed   = latchNext(newFault, failAny[p], resetNow[p]);
			next_status.remoteStatus = next_remote;
			next_status.autoMode     = autoIn;
			next_status.available    = next_avail;
		end

		// ==========================================================
		// Run check timer
		// delay in whole seconds
		wire secondDone = (tick[p] == 32'(SECOND_CYCLES - 1));
		wire delayDone  = (secCnt[p] >= c.runCheckDelay);
		always_comb begin
			next_state  = runState[p];
			next_secCnt = secCnt[p];
			next_tick   = tick[p];
			case (runState[p])
				PIL_IDLE: begin
					next_secCnt = '0;
					next_tick   = '0;
					if (pumpRelay[p] & pumpRunRequest[p])
						next_state = PIL_WAIT;
				end
				PIL_WAIT: begin
					if (!pumpRelay[p]) begin
						next_state = PIL_IDLE;
					end else if (delayDone) begin
						next_state = PIL_CHECK;
					end else if (secondDone) begin
						next_tick   = '0;
						next_secCnt = incSec(secCnt[p]);
					end else begin
						next_tick = incTick(tick[p]);
					end
				end
				PIL_CHECK: begin
					if (!pumpRelay[p])
						next_state = PIL_IDLE;
				end
				default: next_state = PIL_IDLE;
			endcase
		end

		// ==========================================================
		// Registers
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				pumpStatus[p] <= '0;
			end else begin
				pumpStatus[p] <= next_status;
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				pumpRelay[p] <= 1'b0;
			end else begin
				pumpRelay[p] <= next_relay;
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				resetPrev[p] <= 1'b0;
			end else begin
				resetPrev[p] <= rstIn;
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				runState[p] <= PIL_IDLE;
			end else begin
				runState[p] <= next_state;
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				secCnt[p] <= '0;
			end else begin
				secCnt[p] <= next_secCnt;
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				tick[p] <= '0;
			end else begin
				tick[p] <= next_tick;
			end
		end
	end
endmodule // pil_pump_interlock
`default_nettype wire

/* verification/pil_field_model.sv */
// Field side model: contacts and a motor starter run confirm
`timescale 1ns/10ps
`default_nettype none
module pil_field_model (
	input  wire logic       clk,
	input  wire logic       relayOn,
	input  wire logic       motorOk,
	input  wire logic [7:0] contacts,
	output logic [7:0]      fieldIn
);
	logic [1:0] spinUp = 2'h0;
	always_ff @(posedge clk) begin
		spinUp <= {spinUp[0], relayOn & motorOk};
	end
	assign fieldIn = {contacts[7:4], spinUp[1], contacts[2:0]};
endmodule // pil_field_model
`default_nettype wire

/* verification/pil_interlock_checker.sv */
// Port checker for the pump interlock
`timescale 1ns/10ps
`default_nettype none
`include "pil_cfg.svh"
module pil_interlock_checker #(
	parameter int NUM_PUMPS     = `PIL_NUM_PUMPS,
	parameter int NUM_INPUTS    = `PIL_NUM_INPUTS,
	parameter int SECOND_CYCLES = `PIL_SECOND_CYCLES
) (
	input wire logic                                   clk,
	input wire logic                                   rst,
	input wire pil_pkg::pil_pump_cfg_t [NUM_PUMPS-1:0] pumpCfg,
	input wire logic [NUM_PUMPS-1:0]                   relayFunctionAlarm,
	input wire logic [NUM_PUMPS-1:0]                   hostRemoteWrite,
	input wire logic [NUM_PUMPS-1:0]                   hostRemoteValue,
	input wire logic [NUM_PUMPS-1:0]                   pumpRelay,
	input wire logic [NUM_PUMPS-1:0]                   powerFailAlarmRelay,
	input wire logic                                   powerFailFlag,
	input wire pil_pkg::pil_pump_stat_t [NUM_PUMPS-1:0] pumpStatus
);
	import pil_pkg::*;
	wire pil_pump_stat_t s0 = pumpStatus[0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	summary_or_a: assert property (|{s0.runFault, s0.faultA, s0.faultB} |-> s0.pumpFailed)
		else $error("summary flag low");
	failed_off_a: assert property (s0.pumpFailed |-> !pumpRelay[0])
		else $error("failed pump driven");
	pwr_stop_a: assert property (powerFailFlag [*2] |-> pumpRelay == '0)
		else $error("pump runs in power fail");
	pwr_alarm_a: assert property (powerFailFlag [*2] |-> powerFailAlarmRelay == relayFunctionAlarm)
		else $error("alarm relays wrong");
	alarm_clear_a: assert property (!powerFailFlag [*2] |-> powerFailAlarmRelay == '0)
		else $error("alarm relays stuck");
	ignore_new_a: assert property (powerFailFlag && !s0.faultB ##1 powerFailFlag |-> !s0.faultB)
		else $error("new fault in power fail");
	nonpump_idle_a: assert property (pumpCfg[1].relayFunction < 7'h32 |-> !pumpStatus[1].pumpFailed)
		else $error("non-pump relay failed");
	clear_all_a: assert property ($fell(s0.pumpFailed) |-> !(s0.faultA | s0.faultB | s0.runFault))
		else $error("partial fault clear");
	run_delay_a: assert property ($rose(pumpRelay[0]) |=> !s0.runFault [*4])
		else $error("run check too early");
	remote_host_a: assert property (pumpCfg[0].remoteEnableSelect == 4'h0 && hostRemoteWrite[0] && hostRemoteValue[0]
		|-> ##[1:5] s0.remoteStatus)
		else $error("remote flag not written");
endmodule // pil_interlock_checker
bind pil_pump_interlock pil_interlock_checker #(.NUM_PUMPS(NUM_PUMPS), .NUM_INPUTS(NUM_INPUTS),
	.SECOND_CYCLES(SECOND_CYCLES)) u_chk (.clk, .rst, .pumpCfg, .relayFunctionAlarm, .hostRemoteWrite,
	.hostRemoteValue, .pumpRelay, .powerFailAlarmRelay, .powerFailFlag, .pumpStatus);
`default_nettype wire

/* verification/pil_pump_interlock_tb.sv */
// Self-checking bench for the pump interlock
`timescale 1ns/10ps
`default_nettype none
module pil_pump_interlock_tb;
	import pil_pkg::*;
	logic clk = 0, rst = 1, runMode = 0, motorOk = 0;
	logic [7:0] contacts = 0, fieldIn, runReq = 0, hw = 0, hv = 0, hc = 0;
	logic [7:0] pumpRelay, alarmRelay;
	logic       powerFailFlag;
	logic [3:0] gsel = 4'h0;
	pil_pump_cfg_t [7:0] cfg = '0;
	pil_pump_stat_t [7:0] st;
	int err_count = 0, n_checks = 0, cycles = 0;
	logic [7:0] rowIn[4] = '{8'h00, 8'h01, 8'h02, 8'h03};
	logic [2:0] rowExp[4] = '{3'h0, 3'h6, 3'h5, 3'h7};
	always #12.5 clk = ~clk;
	pil_field_model u_field (.clk, .relayOn(pumpRelay[0]), .motorOk, .contacts, .fieldIn);
	pil_pump_interlock #(.SECOND_CYCLES(4)) u_dut (.clk, .rst, .scaledInputValue(fieldIn), .pumpCfg(cfg),
		.powerFailSelect(4'h5), .globalResetSelect(gsel), .relayFunctionAlarm(8'h02), .pumpRunRequest(runReq),
		.hostRemoteWrite(hw), .hostRemoteValue(hv), .hostFaultClear(hc), .runMode, .pumpRelay,
		.powerFailAlarmRelay(alarmRelay), .powerFailFlag, .pumpStatus(st));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (++cycles == 1500) begin
			err_count++;
			results();
		end
	end
	initial begin
		cfg[0] = '{4'h0, 4'h0, 4'h4, 4'h1, 4'h2, 4'h3, 7'h32, 14'h0003};
		cfg[1] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 7'h0c, 14'h0005};
		cyc(6);
		rst = 0;
		cyc(6);
		chk({st[0], powerFailFlag}, 8'h06);
		hw = 8'h01;
		hv = 8'h01;
		cyc(1);
		hw = 0;
		cyc(6);
		chk({7'h0, st[0].remoteStatus}, 8'h01);
		foreach (rowIn[i]) begin
			contacts = rowIn[i];
			cyc(8);
			contacts = 0;
			cyc(8);
			chk({4'h0, st[0].pumpFailed, st[0].faultA, st[0].faultB, st[1].pumpFailed}, {4'h0, rowExp[i], 1'b0});
			hc = 8'h01;
			cyc(1);
			hc = 0;
			cyc(4);
			chk({7'h0, st[0].pumpFailed}, 8'h00);
		end
		runReq = 8'h01;
		cyc(24);
		chk({5'h0, pumpRelay[0], st[0].runFault, st[0].pumpFailed}, 8'h03);
		contacts = 8'h04;
		cyc(8);
		contacts = 0;
		cyc(8);
		chk({7'h0, st[0].pumpFailed}, 8'h01);
		runMode = 1;
		motorOk = 1;
		contacts = 8'h04;
		cyc(8);
		contacts = 0;
		cyc(24);
		chk({5'h0, st[0].pumpFailed, st[0].runFault, pumpRelay[0]}, 8'h01);
		contacts = 8'h12;
		cyc(10);
		chk({powerFailFlag, alarmRelay[1], pumpRelay[0], st[0].faultB, 4'h0}, 8'hc0);
		contacts = 0;
		cyc(10);
		chk({powerFailFlag, alarmRelay[1], pumpRelay[0], st[0].faultB, 4'h0}, 8'h20);
		cfg[0].autoManualSelect = 4'h7;
		cfg[0].remoteEnableSelect = 4'h8;
		cyc(8);
		chk({5'h0, st[0].autoMode, st[0].available, pumpRelay[0]}, 8'h00);
		contacts = 8'h40;
		cyc(8);
		chk({5'h0, st[0].autoMode, st[0].available, pumpRelay[0]}, 8'h07);
		hw = 8'h01;
		hv = 8'h01;
		cyc(1);
		hw = 0;
		cyc(2);
		chk({7'h0, st[0].remoteStatus}, 8'h00);
		contacts = 8'hc0;
		cyc(8);
		chk({7'h0, st[0].remoteStatus}, 8'h01);
		gsel = 4'h6;
		contacts = 8'hc1;
		cyc(8);
		contacts = 8'hc0;
		cyc(8);
		chk({6'h0, st[0].faultA, pumpRelay[0]}, 8'h02);
		contacts = 8'he0;
		cyc(8);
		contacts = 8'hc0;
		chk({7'h0, st[0].pumpFailed}, 8'h00);
		rst = 1;
		cyc(2);
		chk({st[0], pumpRelay[0]}, 8'h00);
		rst = 0;
		cyc(1);
		chk({powerFailFlag, alarmRelay[1], pumpRelay[0], 5'h0}, 8'h00);
		cyc(11);
		chk({7'h0, pumpRelay[0]}, 8'h01);
		results();
	end
endmodule // pil_pump_interlock_tb
`default_nettype wire
